// ==== design/t1ra_pkg.sv ====
package t1ra_pkg;

   // Clock and timing
   localparam int CLK_MHZ           = 100;
   localparam int TXCLK_GAP_NS      = 5200;
   localparam int TXCLK_GAP_CYC     = TXCLK_GAP_NS * CLK_MHZ / 1000;
   localparam int BLUE_WINDOW_US    = 3000;
   localparam int BLUE_WINDOW_CYC   = BLUE_WINDOW_US * CLK_MHZ;
   localparam int LOOP_INTEG_MS     = 48;
   localparam int LINE_KBPS         = 1544;
   localparam int LOOP_INTEG_BITS   = LOOP_INTEG_MS * LINE_KBPS;

   // Alarm thresholds
   localparam int BLUE_SET_MAX_ZEROS = 5;
   localparam int BLUE_CLR_MIN_ZEROS = 6;
   localparam int YEL_CHANNELS       = 256;
   localparam int YEL_MIN_ZEROS      = 254;
   localparam int ESF_RUN            = 16;
   localparam int ESF_CLR_MAX        = 14;
   localparam logic [15:0] ESF_YEL_PATTERN = 16'h00ff;
   localparam int RED_ZEROS          = 192;
   localparam int RED_WINDOW         = 112;
   localparam int RED_MIN_ONES       = 14;
   localparam int LOOP_UP_PERIOD     = 5;
   localparam int LOOP_DN_PERIOD     = 3;

   // Register indices; byte address is four times the index
   localparam logic [7:0] STATUS_ONE_IDX       = 8'h20;
   localparam logic [7:0] RECEIVE_INFO_TWO_IDX = 8'h31;
   localparam logic [7:0] IRQ_MASK_ONE_IDX     = 8'h7f;
   localparam logic [7:0] CTRL_IDX             = 8'h40;
   localparam logic [7:0] IRQ_STATUS_IDX       = 8'h41;
   localparam logic [7:0] IRQ_CLEAR_IDX        = 8'h42;

   // Control fields
   localparam int CTRL_TXCLK_FORCE_BIT = 6;
   localparam int CTRL_YEL_FBIT_BIT    = 2;
   localparam int CTRL_ESF_BIT         = 0;
   localparam int LEVEL_LSB            = 6;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] MASK_RESET   = 8'h00;

   typedef struct packed {
      logic loopUpSeen;
      logic loopDownSeen;
      logic txClockLost;
      logic rxSlipFlag;
      logic rxBlueAlarm;
      logic rxYellowAlarm;
      logic rxCarrierLost;
      logic rxSyncLost;
   } t1ra_status_t;

endpackage : t1ra_pkg

// ==== design/t1ra_alarm.sv ====
`timescale 1ns/1ns
module t1ra_alarm
   import t1ra_pkg::*;
#(
   parameter int BLUE_WIN_CYC = BLUE_WINDOW_CYC,
   parameter int LOOP_BITS    = LOOP_INTEG_BITS
) (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        rxBitValid,
   input  wire logic        rxLinePos,
   input  wire logic        rxLineNeg,
   input  wire logic [1:0]  rxLevel,
   input  wire logic        framerInSync,
   input  wire logic        rxSlipPulse,
   input  wire logic        chanBit2Valid,
   input  wire logic        chanBit2,
   input  wire logic        fBit12Valid,
   input  wire logic        fBit12,
   input  wire logic        fdlWordValid,
   input  wire logic [15:0] fdlWord,
   input  wire logic        txClockIn,
   output logic             txClockOut,
   output logic             irqOutOne
);

   function automatic logic [11:0] regAddr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : regAddr

   t1ra_status_t status_r;
   logic [7:0]   ctrl_r;
   logic [7:0]   irqMask_r;
   logic [7:0]   irqStat_r;
   logic [7:0]   prevStat_r;
   logic [1:0]   level_r;
   logic         rxOne;
   logic         rxZero;

   assign rxOne  = rxBitValid & (rxLinePos | rxLineNeg);
   assign rxZero = rxBitValid & ~(rxLinePos | rxLineNeg);

   ////////////////////////////////////////////////////////////////////////
   // Bus slave: zero wait states, always OKAY

   logic        dataPhase_r;
   logic        dataWrite_r;
   logic [11:0] dataAddr_r;
   logic        addrTaken;
   logic        wrEn;
   logic        statusRead;
   logic [7:0]  rdByte;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addrTaken = hsel & htrans[1] & hready;
   assign wrEn      = dataPhase_r & dataWrite_r;
   assign statusRead = addrTaken & ~hwrite
                       & (haddr == regAddr(STATUS_ONE_IDX));

   always_comb begin
      case (haddr)
         regAddr(STATUS_ONE_IDX):       rdByte = status_r;
         regAddr(RECEIVE_INFO_TWO_IDX): rdByte = {level_r, 6'h00};
         regAddr(IRQ_MASK_ONE_IDX):     rdByte = irqMask_r;
         regAddr(CTRL_IDX):             rdByte = ctrl_r;
         regAddr(IRQ_STATUS_IDX):       rdByte = irqStat_r;
         default:                       rdByte = 8'h00;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         dataPhase_r <= 1'b0;
         dataWrite_r <= 1'b0;
         dataAddr_r  <= 12'h000;
         hrdata      <= 32'h0000_0000;
      end else begin
         dataPhase_r <= addrTaken;
         dataWrite_r <= addrTaken & hwrite;
         if (addrTaken) begin
            dataAddr_r <= haddr;
            hrdata     <= hwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         ctrl_r    <= CTRL_RESET;
         irqMask_r <= MASK_RESET;
      end else if (wrEn) begin
         if (dataAddr_r == regAddr(CTRL_IDX))
            ctrl_r <= hwdata[7:0];
         if (dataAddr_r == regAddr(IRQ_MASK_ONE_IDX))
            irqMask_r <= hwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt: rising status bits latch, set wins over clear

   logic [7:0] irqClr;
   assign irqClr = (wrEn && dataAddr_r == regAddr(IRQ_CLEAR_IDX))
                   ? hwdata[7:0] : 8'h00;

   always_ff @(posedge clock) begin
      if (srst) begin
         irqStat_r  <= 8'h00;
         prevStat_r <= 8'h00;
      end else begin
         prevStat_r <= status_r;
         irqStat_r  <= (irqStat_r & ~irqClr) | (status_r & ~prevStat_r);
      end
   end

   assign irqOutOne = |(irqStat_r & irqMask_r);

   ////////////////////////////////////////////////////////////////////////
   // Loop codes, up/down integration counters tolerate bit errors

   logic [4:0]  loopHist_r;
   logic [19:0] upCnt_r;
   logic [19:0] dnCnt_r;
   logic        upMatch;
   logic        dnMatch;

   assign upMatch = (rxOne == loopHist_r[LOOP_UP_PERIOD-1])
                    && ($countones({loopHist_r[3:0], rxOne}) == 1);
   assign dnMatch = (rxOne == loopHist_r[LOOP_DN_PERIOD-1])
                    && ($countones({loopHist_r[1:0], rxOne}) == 1);

   always_ff @(posedge clock) begin
      if (srst) begin
         loopHist_r <= 5'h00;
         upCnt_r    <= 20'h0_0000;
         dnCnt_r    <= 20'h0_0000;
      end else if (rxBitValid) begin
         loopHist_r <= {loopHist_r[3:0], rxOne};
         if (upMatch && upCnt_r != 20'(LOOP_BITS))
            upCnt_r <= upCnt_r + 20'h0_0001;
         else if (!upMatch && upCnt_r != 20'h0_0000)
            upCnt_r <= upCnt_r - 20'h0_0001;
         if (dnMatch && dnCnt_r != 20'(LOOP_BITS))
            dnCnt_r <= dnCnt_r + 20'h0_0001;
         else if (!dnMatch && dnCnt_r != 20'h0_0000)
            dnCnt_r <= dnCnt_r - 20'h0_0001;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         status_r.loopUpSeen   <= 1'b0;
         status_r.loopDownSeen <= 1'b0;
      end else begin
         if (upCnt_r == 20'(LOOP_BITS))
            status_r.loopUpSeen <= 1'b1;
         else if (upCnt_r == 20'h0_0000)
            status_r.loopUpSeen <= 1'b0;
         if (dnCnt_r == 20'(LOOP_BITS))
            status_r.loopDownSeen <= 1'b1;
         else if (dnCnt_r == 20'h0_0000)
            status_r.loopDownSeen <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit clock watchdog, timed on the system clock

   logic       txPrev_r;
   logic [9:0] txGap_r;
   logic       txEdge;
   assign txEdge = txClockIn ^ txPrev_r;

   always_ff @(posedge clock) begin
      if (srst) begin
         txPrev_r             <= 1'b0;
         txGap_r              <= 10'h000;
         status_r.txClockLost <= 1'b0;
         txClockOut           <= 1'b0;
      end else begin
         txPrev_r <= txClockIn;
         if (txEdge) begin
            txGap_r              <= 10'h000;
            status_r.txClockLost <= 1'b0;
         end else if (txGap_r == 10'(TXCLK_GAP_CYC - 1)) begin
            status_r.txClockLost <= 1'b1;
         end else begin
            txGap_r <= txGap_r + 10'h001;
         end
         // Forced high so downstream sees a steady level, not a stuck low
         txClockOut <= txClockIn
                       | (status_r.txClockLost & ctrl_r[CTRL_TXCLK_FORCE_BIT]);
      end
   end

   a_txclk_lost: assert property (@(posedge clock) disable iff (srst)
      (txGap_r == 10'(TXCLK_GAP_CYC - 1) && !txEdge) |=> status_r.txClockLost)
      else $error("tx clock loss not flagged");
   a_txclk_force: assert property (@(posedge clock) disable iff (srst)
      (status_r.txClockLost && ctrl_r[CTRL_TXCLK_FORCE_BIT]) |=> txClockOut)
      else $error("tx clock output not forced");

   ////////////////////////////////////////////////////////////////////////
   // Slip flag holds until software reads the status register

   always_ff @(posedge clock) begin
      if (srst)
         status_r.rxSlipFlag <= 1'b0;
      else if (rxSlipPulse)
         status_r.rxSlipFlag <= 1'b1;
      else if (statusRead)
         status_r.rxSlipFlag <= 1'b0;
   end

   a_slip_flag: assert property (@(posedge clock) disable iff (srst)
      rxSlipPulse |=> status_r.rxSlipFlag ##1 (status_r.rxSlipFlag || $past(statusRead)))
      else $error("slip not flagged");

   ////////////////////////////////////////////////////////////////////////
   // Blue alarm: few zeros per window; framing zeros keep framed ones clear

   logic [18:0] blueWin_r;
   logic [2:0]  blueZeros_r;
   logic        blueEnd;
   assign blueEnd = (blueWin_r == 19'(BLUE_WIN_CYC - 1));

   always_ff @(posedge clock) begin
      if (srst) begin
         blueWin_r            <= 19'h0_0000;
         blueZeros_r          <= 3'h0;
         status_r.rxBlueAlarm <= 1'b0;
      end else begin
         blueWin_r <= blueEnd ? 19'h0_0000 : blueWin_r + 19'h0_0001;
         if (blueEnd) begin
            blueZeros_r <= 3'h0;
            if (blueZeros_r <= 3'(BLUE_SET_MAX_ZEROS))
               status_r.rxBlueAlarm <= 1'b1;
            else if (blueZeros_r >= 3'(BLUE_CLR_MIN_ZEROS))
               status_r.rxBlueAlarm <= 1'b0;
         end else if (rxZero && blueZeros_r != 3'(BLUE_CLR_MIN_ZEROS)) begin
            blueZeros_r <= blueZeros_r + 3'h1;
         end
      end
   end

   a_blue_set: assert property (@(posedge clock) disable iff (srst)
      (blueEnd && blueZeros_r <= 3'(BLUE_SET_MAX_ZEROS)) |=> status_r.rxBlueAlarm)
      else $error("blue alarm not set");
   a_blue_clear: assert property (@(posedge clock) disable iff (srst)
      (blueEnd && blueZeros_r >= 3'(BLUE_CLR_MIN_ZEROS)) |=> !status_r.rxBlueAlarm)
      else $error("blue alarm not cleared");

   ////////////////////////////////////////////////////////////////////////
   // Yellow alarm in three framing modes

   logic       esfMode;
   logic       fbitMode;
   logic [7:0] chanCnt_r;
   logic [8:0] chanZeros_r;
   logic [8:0] zerosNow;
   logic [1:0] fbitHist_r;
   logic [4:0] esfRun_r;
   logic [3:0] esfWin_r;
   logic [4:0] esfHits_r;
   logic [4:0] hitsNow;
   logic       fdlHit;

   assign esfMode  = ctrl_r[CTRL_ESF_BIT];
   assign fbitMode = ctrl_r[CTRL_YEL_FBIT_BIT];
   assign zerosNow = chanZeros_r + {8'h00, ~chanBit2};
   assign fdlHit   = (fdlWord == ESF_YEL_PATTERN);
   assign hitsNow  = esfHits_r + {4'h0, fdlHit};

   always_ff @(posedge clock) begin
      if (srst) begin
         chanCnt_r              <= 8'h00;
         chanZeros_r            <= 9'h000;
         fbitHist_r             <= 2'h0;
         esfRun_r               <= 5'h00;
         esfWin_r               <= 4'h0;
         esfHits_r              <= 5'h00;
         status_r.rxYellowAlarm <= 1'b0;
      end else if (esfMode) begin
         if (fdlWordValid) begin
            esfRun_r  <= fdlHit ? esfRun_r + {4'h0, esfRun_r != 5'(ESF_RUN)}
                                : 5'h00;
            esfWin_r  <= esfWin_r + 4'h1;
            esfHits_r <= (esfWin_r == 4'hf) ? 5'h00 : hitsNow;
            if (fdlHit && esfRun_r == 5'(ESF_RUN - 1))
               status_r.rxYellowAlarm <= 1'b1;
            else if (esfWin_r == 4'hf && hitsNow <= 5'(ESF_CLR_MAX))
               status_r.rxYellowAlarm <= 1'b0;
         end
      end else if (fbitMode) begin
         if (fBit12Valid) begin
            fbitHist_r <= {fbitHist_r[0], fBit12};
            if (fbitHist_r[0] && fBit12)
               status_r.rxYellowAlarm <= 1'b1;
            else if (!fbitHist_r[0] && !fBit12)
               status_r.rxYellowAlarm <= 1'b0;
         end
      end else if (chanBit2Valid) begin
         chanCnt_r <= chanCnt_r + 8'h01;
         if (chanCnt_r == 8'(YEL_CHANNELS - 1)) begin
            chanZeros_r            <= 9'h000;
            status_r.rxYellowAlarm <= (zerosNow >= 9'(YEL_MIN_ZEROS));
         end else begin
            chanZeros_r <= zerosNow;
         end
      end
   end

   // Second one in a row; the first is held in the history bit
   sequence s_fbit_one;
      fBit12Valid && fBit12 && fbitMode && !esfMode;
   endsequence
   a_yel_fbit: assert property (@(posedge clock) disable iff (srst)
      (fbitHist_r[0] ##0 s_fbit_one)
      |=> status_r.rxYellowAlarm)
      else $error("f-bit yellow not set");
   a_yel_esf: assert property (@(posedge clock) disable iff (srst)
      (esfMode && fdlWordValid && fdlHit && esfRun_r == 5'(ESF_RUN - 1))
      |=> status_r.rxYellowAlarm)
      else $error("esf yellow not set");

   ////////////////////////////////////////////////////////////////////////
   // Red alarm: long zero run sets, ones density window clears

   logic [7:0] zeroRun_r;
   logic       redWin_r;
   logic [6:0] redBits_r;
   logic [3:0] redOnes_r;

   always_ff @(posedge clock) begin
      if (srst) begin
         zeroRun_r              <= 8'h00;
         redWin_r               <= 1'b0;
         redBits_r              <= 7'h00;
         redOnes_r              <= 4'h0;
         status_r.rxCarrierLost <= 1'b0;
      end else if (rxBitValid) begin
         zeroRun_r <= rxOne ? 8'h00
                    : zeroRun_r + {7'h00, zeroRun_r != 8'(RED_ZEROS)};
         if (rxZero && zeroRun_r == 8'(RED_ZEROS - 1)) begin
            status_r.rxCarrierLost <= 1'b1;
            redWin_r               <= 1'b0;
         end else if (status_r.rxCarrierLost) begin
            if (!redWin_r) begin
               // Window opens only on a one
               redWin_r  <= rxOne;
               redBits_r <= 7'h01;
               redOnes_r <= 4'h1;
            end else begin
               redBits_r <= redBits_r + 7'h01;
               redOnes_r <= redOnes_r + {3'h0, rxOne};
               if (rxOne && redOnes_r == 4'(RED_MIN_ONES - 1)) begin
                  status_r.rxCarrierLost <= 1'b0;
                  redWin_r               <= 1'b0;
               end else if (redBits_r == 7'(RED_WINDOW)) begin
                  redWin_r <= 1'b0;
               end
            end
         end
      end
   end

   a_red_set: assert property (@(posedge clock) disable iff (srst)
      (rxZero && zeroRun_r == 8'(RED_ZEROS - 1)) |=> status_r.rxCarrierLost)
      else $error("carrier loss not set");
   a_red_clear: assert property (@(posedge clock) disable iff (srst)
      (redWin_r && rxOne && redOnes_r == 4'(RED_MIN_ONES - 1)
       && !(zeroRun_r == 8'(RED_ZEROS - 1)))
      |=> !status_r.rxCarrierLost)
      else $error("carrier loss not cleared");

   ////////////////////////////////////////////////////////////////////////
   // Sync loss and receive level

   always_ff @(posedge clock) begin
      if (srst) begin
         status_r.rxSyncLost <= 1'b1;
         level_r             <= 2'h0;
      end else begin
         status_r.rxSyncLost <= ~framerInSync;
         level_r             <= rxLevel;
      end
   end

   a_sync_lost: assert property (@(posedge clock) disable iff (srst)
      framerInSync ##1 framerInSync |-> !status_r.rxSyncLost)
      else $error("sync loss stuck");
   a_irq_latch: assert property (@(posedge clock) disable iff (srst)
      $rose(status_r.rxCarrierLost) ##1 irqMask_r[1] |-> irqOutOne)
      else $error("interrupt not raised");

endmodule : t1ra_alarm

// ==== verification/t1ra_line_model.sv ====
`timescale 1ns/1ns
module t1ra_line_model (
   input  wire logic clock,
   output logic      rxBitValid,
   output logic      rxLinePos,
   output logic      rxLineNeg
);
   logic markPos = 1'b1;
   initial begin
      rxBitValid = 1'b0;
      rxLinePos  = 1'b0;
      rxLineNeg  = 1'b0;
   end
   // Each repeat sends a run of zeros, then a run of ones; marks alternate
   task automatic send_bits(input int zeros, input int ones, input int reps);
      for (int r = 0; r < reps; r++) begin
         for (int i = 0; i < zeros + ones; i++) begin
            rxBitValid <= 1'b1;
            rxLinePos  <= (i >= zeros) && markPos;
            rxLineNeg  <= (i >= zeros) && !markPos;
            if (i >= zeros) markPos = !markPos;
            @(posedge clock);
         end
      end
      // Idle rails carry junk so a stale bit can never look valid
      rxBitValid <= 1'b0;
      rxLinePos  <= ~rxLinePos;
      rxLineNeg  <= ~rxLineNeg;
      @(posedge clock);
   endtask : send_bits
endmodule : t1ra_line_model

// ==== verification/test_t1_receive_alarm_status.sv ====
`timescale 1ns/1ns
module test_t1_receive_alarm_status;
   import t1ra_pkg::*;
   // Short windows keep the run brief
   localparam int BLUE_W = 200;
   localparam int LOOP_B = 20;
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic        hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic [1:0]  rxLevel = 2'h0;
   logic        framerInSync = 1'b0;
   logic        rxSlipPulse = 1'b0;
   logic        chanBit2Valid = 1'b0;
   logic        chanBit2 = 1'b0;
   logic        fBit12Valid = 1'b0;
   logic        fBit12 = 1'b0;
   logic        fdlWordValid = 1'b0;
   logic [15:0] fdlWord = 16'h0;
   logic        txClockIn = 1'b0;
   logic        txRun = 1'b1;
   logic        txClockOut;
   logic        irqOutOne;
   logic        rxBitValid;
   logic        rxLinePos;
   logic        rxLineNeg;
   logic [31:0] rd;
   int          nErrors = 0;
   int          checked = 0;
   int          cyc = 0;
   wire         hready = hreadyout;

   always #5 clock = ~clock;
   always @(posedge clock) begin
      if (txRun) txClockIn <= ~txClockIn;
      else txClockIn <= 1'b0;
   end

   t1ra_alarm #(.BLUE_WIN_CYC(BLUE_W), .LOOP_BITS(LOOP_B)) u_dut (
      .clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(),
      .rxBitValid(rxBitValid), .rxLinePos(rxLinePos),
      .rxLineNeg(rxLineNeg), .rxLevel(rxLevel),
      .framerInSync(framerInSync), .rxSlipPulse(rxSlipPulse),
      .chanBit2Valid(chanBit2Valid), .chanBit2(chanBit2),
      .fBit12Valid(fBit12Valid), .fBit12(fBit12),
      .fdlWordValid(fdlWordValid), .fdlWord(fdlWord),
      .txClockIn(txClockIn), .txClockOut(txClockOut),
      .irqOutOne(irqOutOne));
   t1ra_line_model u_line (.clock(clock), .rxBitValid(rxBitValid),
      .rxLinePos(rxLinePos), .rxLineNeg(rxLineNeg));

////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (nErrors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   // Whole run needs well under this many cycles
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         nErrors++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         nErrors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {2'h0, idx, 2'h0};
      hwrite <= wr;
      do @(posedge clock); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge clock); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic stat_bit(input int b, input logic v);
      bus(1'b0, STATUS_ONE_IDX, 8'h00);
      chk({31'h0, rd[b]}, {31'h0, v});
   endtask : stat_bit

   task automatic bit2(input int n, input logic v);
      repeat (n) begin
         chanBit2Valid <= 1'b1;
         chanBit2      <= v;
         @(posedge clock);
      end
      chanBit2Valid <= 1'b0;
      @(posedge clock);
   endtask : bit2

   task automatic fbit(input logic v);
      fBit12Valid <= 1'b1;
      fBit12      <= v;
      @(posedge clock);
      fBit12Valid <= 1'b0;
      @(posedge clock);
   endtask : fbit

   task automatic fdl(input int n, input logic [15:0] w);
      repeat (n) begin
         fdlWordValid <= 1'b1;
         fdlWord      <= w;
         @(posedge clock);
      end
      fdlWordValid <= 1'b0;
      @(posedge clock);
   endtask : fdl

////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      bus(1'b0, STATUS_ONE_IDX, 8'h00);
      chk(rd, 32'h1);
      bus(1'b1, STATUS_ONE_IDX, 8'hff);
      bus(1'b0, STATUS_ONE_IDX, 8'h00);
      chk(rd, 32'h1);
      bus(1'b0, 8'h10, 8'h00);
      chk(rd, 32'h0);
      bus(1'b0, IRQ_MASK_ONE_IDX, 8'h00);
      chk(rd, {24'h0, MASK_RESET});
      framerInSync <= 1'b1;
      repeat (2) @(posedge clock);
      stat_bit(0, 1'b0);
   endtask : t_reset

   task automatic t_level;
      for (int l = 0; l < 4; l++) begin
         rxLevel <= 2'(l);
         repeat (2) @(posedge clock);
         bus(1'b0, RECEIVE_INFO_TWO_IDX, 8'h00);
         chk(rd, {24'h0, 2'(l), 6'h0});
      end
   endtask : t_level

   task automatic t_slip;
      bus(1'b1, IRQ_CLEAR_IDX, 8'hff);
      rxSlipPulse <= 1'b1;
      @(posedge clock);
      rxSlipPulse <= 1'b0;
      repeat (2) @(posedge clock);
      chk({31'h0, irqOutOne}, 32'h0);
      bus(1'b0, IRQ_STATUS_IDX, 8'h00);
      chk({31'h0, rd[4]}, 32'h1);
      stat_bit(4, 1'b1);
      stat_bit(4, 1'b0);
   endtask : t_slip

   task automatic t_txclk;
      txRun <= 1'b0;
      repeat (400) @(posedge clock);
      stat_bit(5, 1'b0);
      repeat (160) @(posedge clock);
      stat_bit(5, 1'b1);
      chk({31'h0, txClockOut}, 32'h0);
      bus(1'b1, CTRL_IDX, 8'h40);
      // Output register follows the control write one edge later
      repeat (2) @(posedge clock);
      chk({31'h0, txClockOut}, 32'h1);
      txRun <= 1'b1;
      bus(1'b1, CTRL_IDX, 8'h00);
      repeat (3) @(posedge clock);
      stat_bit(5, 1'b0);
   endtask : t_txclk

   task automatic t_line;
      u_line.send_bits(4, 1, 40);
      stat_bit(7, 1'b1);
      u_line.send_bits(2, 1, 60);
      stat_bit(6, 1'b1);
      stat_bit(7, 1'b0);
      u_line.send_bits(1, 44, 10);
      stat_bit(3, 1'b1);
      // Sync loss stays clear while blue is up; blue does not depend on framer sync
      chk({31'h0, rd[0]}, 32'h0);
      u_line.send_bits(1, 29, 14);
      stat_bit(3, 1'b0);
      // Red alarm raises the only unmasked interrupt
      bus(1'b1, IRQ_CLEAR_IDX, 8'hff);
      bus(1'b1, IRQ_MASK_ONE_IDX, 8'h02);
      u_line.send_bits(191, 0, 1);
      stat_bit(1, 1'b0);
      u_line.send_bits(1, 0, 1);
      stat_bit(1, 1'b1);
      chk({31'h0, irqOutOne}, 32'h1);
      u_line.send_bits(0, 1, 1);
      u_line.send_bits(7, 1, 12);
      stat_bit(1, 1'b1);
      u_line.send_bits(7, 1, 1);
      stat_bit(1, 1'b0);
      bus(1'b1, IRQ_CLEAR_IDX, 8'h02);
      @(posedge clock);
      chk({31'h0, irqOutOne}, 32'h0);
   endtask : t_line

   task automatic t_yellow;
      bit2(254, 1'b0);
      bit2(2, 1'b1);
      stat_bit(2, 1'b1);
      bit2(253, 1'b0);
      bit2(3, 1'b1);
      stat_bit(2, 1'b0);
      bus(1'b1, CTRL_IDX, 8'h04);
      fbit(1'b1);
      stat_bit(2, 1'b0);
      fbit(1'b1);
      stat_bit(2, 1'b1);
      fbit(1'b0);
      stat_bit(2, 1'b1);
      fbit(1'b0);
      stat_bit(2, 1'b0);
      bus(1'b1, CTRL_IDX, 8'h01);
      fdl(15, ESF_YEL_PATTERN);
      stat_bit(2, 1'b0);
      fdl(1, ESF_YEL_PATTERN);
      stat_bit(2, 1'b1);
      fdl(15, ESF_YEL_PATTERN);
      fdl(1, 16'h0000);
      stat_bit(2, 1'b1);
      fdl(14, ESF_YEL_PATTERN);
      fdl(2, 16'hff00);
      stat_bit(2, 1'b0);
   endtask : t_yellow

   initial begin
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      t_reset();
      t_level();
      t_slip();
      t_txclk();
      t_line();
      t_yellow();
      report_and_stop();
   end
endmodule : test_t1_receive_alarm_status
